// ==== bench/sccc_pin_model.sv ====
// model of the signals outside the channel and count clock pins
`timescale 1ns/1ns
`default_nettype none
module sccc_pin_model #(
    parameter int NCH = 6
) (
    input  wire logic           clk,
    input  wire logic [NCH-1:0] drive_lvl,
    input  wire logic           ext_run,
    input  wire logic [NCH-1:0] pin_o,
    input  wire logic [NCH-1:0] pin_oe,
    output logic [NCH-1:0]      pin_lvl,
    output logic                ext_clk
);
    int ph = 0;
    initial ext_clk = 1'b0;
    // outside source holds its level when not counting; changes just after the rising edge
    always @(posedge clk) begin
        if (ext_run) begin
            ph = (ph + 1) % 3;
            if (ph == 0) begin
                ext_clk <= ~ext_clk;
            end
        end
    end
    // freed or capture pins show the outside level
    assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & drive_lvl);
endmodule : sccc_pin_model
`default_nettype wire

// ==== bench/sccc_properties.sv ====
// port-level assertion checker for the capture/compare unit
`timescale 1ns/1ns
`default_nettype none
module sccc_properties
    import sccc_pkg::*;
#(
    parameter int NCH = 6
) (
    input wire logic           clk,
    input wire logic           sys_rst,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [7:0]     paddr,
    input wire logic [31:0]    pwdata,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    input wire logic           external_count_clock_pin,
    input wire logic [NCH-1:0] channel_pin_i,
    input wire logic [NCH-1:0] channel_pin_o,
    input wire logic [NCH-1:0] channel_pin_oe,
    input wire logic           cpu_irq_req
);
    // ********************************
    // shadow of channel control writes
    // ********************************
    logic [7:0] ctl_r [NCH];
    logic       wr;
    assign wr = psel && penable && pwrite && paddr[1:0] == 2'h0;
    always_ff @(posedge clk) begin
        for (int n = 0; n < NCH; n++) begin
            if (sys_rst) begin
                ctl_r[n] <= 8'h00;
            end else if (wr && paddr[7:2] == CH0_CTRL_IDX + CH_STRIDE * 6'(n)) begin
                ctl_r[n] <= pwdata[7:0];
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence cap_edge_s;
        $rose(channel_pin_i[1]) && !ctl_r[0][CH_LINK_BIT] && ctl_r[1][6:2] == 5'h11
            && !cpu_irq_req;
    endsequence
    pready_high_a: assert property (psel |-> pready)
        else $error("pready low in a transfer");
    slverr_align_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    slverr_map_a: assert property (psel && penable && paddr[1:0] == 2'h0
        |-> pslverr == (paddr[7:2] < MAIN_CTRL_IDX || paddr[7:2] > LAST_IDX))
        else $error("slave error does not follow the map");
    rdata_hold_a: assert property (!$past(sys_rst) && !$past(psel && !penable && !pwrite)
        |-> $stable(prdata))
        else $error("read data moved without a read");
    reset_quiet_a: assert property ($past(sys_rst) |->
        channel_pin_oe == '0 && channel_pin_o == '0 && !cpu_irq_req)
        else $error("outputs not quiet after reset");
    odd_pin_free_a: assert property (ctl_r[0][CH_LINK_BIT] |-> !channel_pin_oe[1])
        else $error("odd pin driven while linked");
    cmp_drive_a: assert property (!ctl_r[0][CH_LINK_BIT] && ctl_r[0][CH_MODE_BIT]
        |-> channel_pin_oe[0] == (ctl_r[0][3:2] != ELS_NONE))
        else $error("compare pin enable wrong");
    cap_sync_a: assert property (cap_edge_s |=> !cpu_irq_req)
        else $error("capture seen before synchronising");
    cap_flag_a: assert property (cap_edge_s |-> ##[2:6] cpu_irq_req)
        else $error("capture raised no request");
endmodule : sccc_properties
bind sccc_unit sccc_properties #(.NCH(NCH)) chk_u (.clk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .external_count_clock_pin,
    .channel_pin_i, .channel_pin_o, .channel_pin_oe, .cpu_irq_req);
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the capture/compare unit
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sccc_pkg::*;
    logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, ext_clk, irq, err, ext_run = 1'b0;
    logic [5:0]  drv = 6'h00, pin_i, pin_o, pin_oe;
    logic [15:0] v, m;
    int          errors = 0, checks = 0, n;
    always #20 clk = ~clk;
    sccc_unit dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_clock_pin(ext_clk), .channel_pin_i(pin_i),
        .channel_pin_o(pin_o), .channel_pin_oe(pin_oe), .cpu_irq_req(irq));
    sccc_pin_model pins_u (.clk(clk), .drive_lvl(drv), .ext_run(ext_run), .pin_o(pin_o),
        .pin_oe(pin_oe), .pin_lvl(pin_i), .ext_clk(ext_clk));
    // ********************************
    // tasks
    // ********************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd16(input logic [5:0] idx);
        apb(1'b0, idx, 8'h00);
        v[15:8] = rd[7:0];
        apb(1'b0, idx + CH_HI_OFS, 8'h00);
        v[7:0] = rd[7:0];
    endtask : rd16
    function automatic int ticks(input int k, input int cyc);
        return cyc / ((k < 7) ? (1 << k) : 6);
    endfunction : ticks
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        finish_test();
    end
    // ********************************
    // scenarios
    // ********************************
    initial begin
        n = $urandom(58448);
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, MAIN_CTRL_IDX, 8'h00);
        check(rd, 32'h20);
        apb(1'b0, MOD_HI_IDX, 8'h00);
        check(rd, 32'hff);
        apb(1'b0, RSVD_IDX, 8'h00);
        check(rd, 32'h0);
        apb(1'b1, 6'h3a, 8'h55);
        check({31'h0, err}, 32'h1);
        for (int k = 0; k < 8; k++) begin
            ext_run <= (k == 7);
            apb(1'b1, MAIN_CTRL_IDX, 8'h30);
            apb(1'b1, MAIN_CTRL_IDX, 8'(k));
            repeat (128) @(posedge clk);
            apb(1'b1, MAIN_CTRL_IDX, 8'h20 | 8'(k));
            rd16(CNT_HI_IDX);
            m = v;
            rd16(CNT_HI_IDX);
            check({16'h0, v}, {16'h0, m});
            check({31'h0, v >= ticks(k, 128) - 1 && v <= ticks(k, 136) + 1}, 32'h1);
        end
        m = 16'($urandom_range(15, 3));
        apb(1'b1, MOD_HI_IDX, 8'h00);
        apb(1'b1, MOD_LO_IDX, m[7:0]);
        apb(1'b0, MOD_LO_IDX, 8'h00);
        check(rd, {24'h0, m[7:0]});
        apb(1'b1, MAIN_CTRL_IDX, 8'h50);
        repeat (20) @(posedge clk);
        apb(1'b1, MAIN_CTRL_IDX, 8'he0);
        apb(1'b0, MAIN_CTRL_IDX, 8'h00);
        check(rd, 32'he0);
        check({31'h0, irq}, 32'h1);
        rd16(CNT_HI_IDX);
        check({31'h0, v <= m}, 32'h1);
        apb(1'b1, MAIN_CTRL_IDX, 8'h60);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, MOD_HI_IDX, 8'hff);
        apb(1'b1, MOD_LO_IDX, 8'hff);
        // flag left set on later passes: capture must still land
        for (int e = 1; e < 4; e++) begin
            apb(1'b1, MAIN_CTRL_IDX, 8'h00);
            repeat ($urandom_range(40, 1)) @(posedge clk);
            apb(1'b1, MAIN_CTRL_IDX, 8'h20);
            rd16(CNT_HI_IDX);
            m = v;
            apb(1'b1, CH0_CTRL_IDX + CH_STRIDE, 8'hc0 | 8'(e << 2));
            drv[1] <= ~drv[1];
            repeat (8) @(posedge clk);
            rd16(CH0_CTRL_IDX + CH_STRIDE + CH_HI_OFS);
            check({16'h0, v}, {16'h0, m});
            apb(1'b0, CH0_CTRL_IDX + CH_STRIDE, 8'h00);
            check(rd, {24'h0, 8'hc0 | 8'(e << 2)});
        end
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        rd16(CH0_CTRL_IDX + CH_STRIDE + CH_HI_OFS);
        check({16'h0, v}, {16'h0, m});
        v = 16'($urandom_range(60, 2));
        // compare value written while the counter stands, so no lap is disturbed
        apb(1'b1, CH0_CTRL_IDX + CH_HI_OFS, 8'h00);
        apb(1'b1, CH0_CTRL_IDX + CH_LO_OFS, v[7:0]);
        apb(1'b1, CH0_CTRL_IDX, 8'h1c);
        apb(1'b1, MAIN_CTRL_IDX, 8'h10);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pin_o[0] !== 1'b1 && n < 200);
        check({31'h0, n >= v - 1 && n <= v + 1}, 32'h1);
        check({31'h0, pin_oe[0]}, 32'h1);
        apb(1'b1, CH0_CTRL_IDX + CH_STRIDE, 8'h1c);
        apb(1'b1, CH0_CTRL_IDX, 8'hbc);
        @(negedge clk);
        check({31'h0, pin_oe[1]}, 32'h0);
        check({31'h0, pin_oe[0]}, 32'h1);
        // buffered pair: clear on compare, toggle on overflow, modulo 0x80
        apb(1'b1, MAIN_CTRL_IDX, 8'h30);
        apb(1'b1, MOD_HI_IDX, 8'h00);
        apb(1'b1, MOD_LO_IDX, 8'h80);
        apb(1'b1, CH0_CTRL_IDX, 8'hba);
        apb(1'b1, MAIN_CTRL_IDX, 8'h10);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pin_o[0] !== 1'b0 && n < 300);
        check({31'h0, n >= v - 1 && n <= v + 1}, 32'h1);
        m = v + 16'h0003;
        // only the inactive odd registers are rewritten
        apb(1'b1, CH0_CTRL_IDX + CH_STRIDE + CH_HI_OFS, 8'h00);
        apb(1'b1, CH0_CTRL_IDX + CH_STRIDE + CH_LO_OFS, m[7:0]);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pin_o[0] !== 1'b1 && n < 300);
        check({31'h0, pin_o[0]}, 32'h1);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pin_o[0] !== 1'b0 && n < 300);
        check({31'h0, n >= m - 1 && n <= m + 1}, 32'h1);
        finish_test();
    end
endmodule : tb
`default_nettype wire

// ==== design/sccc_pkg.sv ====
// constants for the six-channel capture/compare unit
package sccc_pkg;
    // ********************************
    // register indices (byte address = 4 * index)
    // ********************************
    localparam logic [5:0] MAIN_CTRL_IDX = 6'h20;
    localparam logic [5:0] RSVD_IDX      = 6'h21;
    localparam logic [5:0] CNT_HI_IDX    = 6'h22;
    localparam logic [5:0] CNT_LO_IDX    = 6'h23;
    localparam logic [5:0] MOD_HI_IDX    = 6'h24;
    localparam logic [5:0] MOD_LO_IDX    = 6'h25;
    localparam logic [5:0] CH0_CTRL_IDX  = 6'h26;
    localparam logic [5:0] CH_STRIDE     = 6'h03;
    localparam logic [5:0] CH_HI_OFS     = 6'h01;
    localparam logic [5:0] CH_LO_OFS     = 6'h02;
    localparam logic [5:0] LAST_IDX      = 6'h37;
    // ********************************
    // main control bit positions
    // ********************************
    localparam int OVF_FLAG_BIT = 7;
    localparam int OVF_IE_BIT   = 6;
    localparam int HALT_BIT     = 5;
    localparam int CRST_BIT     = 4;
    // ********************************
    // channel control bit positions
    // ********************************
    localparam int CH_FLAG_BIT = 7;
    localparam int CH_IE_BIT   = 6;
    localparam int CH_LINK_BIT = 5;
    localparam int CH_MODE_BIT = 4;
    localparam int CH_ELS_HI   = 3;
    localparam int CH_ELS_LO   = 2;
    localparam int CH_TOV_BIT  = 1;
    localparam int CH_MAX_BIT  = 0;
    // ********************************
    // encodings and reset values
    // ********************************
    localparam logic [2:0]  PS_EXT_CLK  = 3'h7;
    localparam logic [1:0]  ELS_NONE    = 2'h0;
    localparam logic [1:0]  ELS_RISE    = 2'h1;
    localparam logic [1:0]  ELS_FALL    = 2'h2;
    localparam logic [1:0]  ELS_BOTH    = 2'h3;
    localparam logic [1:0]  OC_TOGGLE   = 2'h1;
    localparam logic [1:0]  OC_CLEAR    = 2'h2;
    localparam logic [1:0]  OC_SET      = 2'h3;
    localparam logic [15:0] MOD_RESET   = 16'hffff;
    localparam logic        HALT_RESET  = 1'h1;
    localparam logic [5:0]  PRE_ALL1    = 6'h3f;
    localparam int          SYNC_STAGES = 3;
endpackage : sccc_pkg

// ==== design/sccc_unit.sv ====
// capture/compare unit: counter, prescaler, channels and APB slave
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - 16-bit counter, free-running or modulo, shared base.
// - modulo limit comes from high/low modulo registers.
// - counter reads never disturb counting.
// - six channels, each capture or compare.
// - seven prescaled rates or external pin, 3-bit select.
// - pin edge latches counter into channel value.
// - two select bits choose the capture edge.
// - captured value reflects synchroniser delay, up to three more.
// - capture happens whether flag set or clear.
// - capture sets flag, interrupt request if enabled.
// - new capture overwrites an unread old one.
// - reset leaves channel value registers unchanged.
// - compare match sets, clears or toggles pin.
// - rewrite past counter misses compare that period.
// - link bit pairs channels, even pin driven.
// - even value first; last-written set takes over at overflow.
// - linked: even control only, odd pin free.
// - halt and counter-reset bits in main control.
module sccc_unit
    import sccc_pkg::*;
#(
    parameter int NCH = 6
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             external_count_clock_pin,
    input  wire logic [NCH-1:0]   channel_pin_i,
    output logic [NCH-1:0]        channel_pin_o,
    output logic [NCH-1:0]        channel_pin_oe,
    output logic                  cpu_irq_req
);
    localparam int NP = NCH / 2;

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [5:0]                    pre;
        logic [15:0]                   cnt;
        logic [15:0]                   modv;
        logic                          tof;
        logic                          toie;
        logic                          halt;
        logic [2:0]                    ps;
        logic [SYNC_STAGES-1:0]        ext_sy;
        logic                          ext_f;
        logic [NCH-1:0][15:0]          chv;
        logic [NCH-1:0]                cf;
        logic [NCH-1:0]                cie;
        logic [NCH-1:0]                mb;
        logic [NCH-1:0]                ma;
        logic [NCH-1:0][1:0]           els;
        logic [NCH-1:0]                tov;
        logic [NCH-1:0]                cmax;
        logic [NCH-1:0][SYNC_STAGES-1:0] pin_sy;
        logic [NCH-1:0]                pin_f;
        logic [NCH-1:0]                pin_o;
        logic [NP-1:0]                 act;
        logic [NP-1:0]                 pend;
        logic [31:0]                   rdata;
    } sccc_state_t;

    sccc_state_t st_r;
    sccc_state_t st_nxt;

    if (NCH < 2 || NCH > 6 || (NCH % 2) != 0) begin : g_bad_nch
        $error("sccc_unit: NCH must be 2, 4 or 6");
    end

    // ********************************
    // bus decode
    // ********************************
    logic [5:0] idx;
    logic       mapped;
    logic       setup;
    logic       wr;
    assign idx    = paddr[7:2];
    assign mapped = (paddr[1:0] == 2'h0) && (idx >= MAIN_CTRL_IDX)
                    && (idx <= MAIN_CTRL_IDX + 6'(5 + 3 * NCH));
    assign setup  = psel && !penable;
    assign wr     = psel && penable && pwrite && mapped;
    // zero wait states: read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = st_r.rdata;

    // ********************************
    // next state
    // ********************************
    always_comb begin
        logic [5:0]  lmask;
        logic        tick;
        logic        step;
        logic        wrap;
        logic        ovf;
        logic [15:0] cnt_n;
        logic [5:0]  cidx;
        logic        link;
        logic        odd;
        logic        oc;
        logic        ic;
        logic        rise;
        logic        fall;
        logic        hit;
        logic        cap;
        logic [15:0] cmpv;
        logic [7:0]  rb;
        int          p;
        lmask = 6'h00;
        tick  = 1'b0;
        step  = 1'b0;
        wrap  = 1'b0;
        ovf   = 1'b0;
        cnt_n = 16'h0000;
        cidx  = 6'h00;
        link  = 1'b0;
        odd   = 1'b0;
        oc    = 1'b0;
        ic    = 1'b0;
        rise  = 1'b0;
        fall  = 1'b0;
        hit   = 1'b0;
        cap   = 1'b0;
        cmpv  = 16'h0000;
        rb    = 8'h00;
        p     = 0;
        st_nxt = st_r;

        // pin synchronisers: a change counts once stages 2 and 3 agree
        st_nxt.ext_sy = {st_r.ext_sy[SYNC_STAGES-2:0], external_count_clock_pin};
        if (st_r.ext_sy[1] == st_r.ext_sy[2]) begin
            st_nxt.ext_f = st_r.ext_sy[2];
        end
        for (int i = 0; i < NCH; i++) begin
            st_nxt.pin_sy[i] = {st_r.pin_sy[i][SYNC_STAGES-2:0], channel_pin_i[i]};
            if (st_r.pin_sy[i][1] == st_r.pin_sy[i][2]) begin
                st_nxt.pin_f[i] = st_r.pin_sy[i][2];
            end
        end

        // prescaler and counter
        st_nxt.pre = st_r.pre + 6'h01;
        lmask = ~(PRE_ALL1 << st_r.ps);
        if (st_r.ps == PS_EXT_CLK) begin
            tick = st_nxt.ext_f && !st_r.ext_f;
        end else begin
            tick = (st_r.pre & lmask) == lmask;
        end
        step  = tick && !st_r.halt;
        wrap  = st_r.cnt == st_r.modv;
        ovf   = step && wrap;
        cnt_n = wrap ? 16'h0000 : st_r.cnt + 16'h0001;
        if (step) begin
            st_nxt.cnt = cnt_n;
        end

        // register writes; hardware sets below win over clears
        if (wr) begin
            case (idx)
                MAIN_CTRL_IDX: begin
                    if (!pwdata[OVF_FLAG_BIT]) begin
                        st_nxt.tof = 1'b0;
                    end
                    st_nxt.toie = pwdata[OVF_IE_BIT];
                    st_nxt.halt = pwdata[HALT_BIT];
                    st_nxt.ps   = pwdata[2:0];
                    if (pwdata[CRST_BIT]) begin
                        st_nxt.cnt = 16'h0000;
                        st_nxt.pre = 6'h00;
                    end
                end
                MOD_HI_IDX: st_nxt.modv[15:8] = pwdata[7:0];
                MOD_LO_IDX: st_nxt.modv[7:0]  = pwdata[7:0];
                default: ;
            endcase
            for (int i = 0; i < NCH; i++) begin
                cidx = CH0_CTRL_IDX + 6'(3 * i);
                if (idx == cidx) begin
                    if (!pwdata[CH_FLAG_BIT]) begin
                        st_nxt.cf[i] = 1'b0;
                    end
                    st_nxt.cie[i]  = pwdata[CH_IE_BIT];
                    st_nxt.mb[i]   = (i % 2 == 0) ? pwdata[CH_LINK_BIT] : 1'b0;
                    st_nxt.ma[i]   = pwdata[CH_MODE_BIT];
                    st_nxt.els[i]  = pwdata[CH_ELS_HI:CH_ELS_LO];
                    st_nxt.tov[i]  = pwdata[CH_TOV_BIT];
                    st_nxt.cmax[i] = pwdata[CH_MAX_BIT];
                end
                if (idx == cidx + CH_HI_OFS || idx == cidx + CH_LO_OFS) begin
                    if (idx == cidx + CH_HI_OFS) begin
                        st_nxt.chv[i][15:8] = pwdata[7:0];
                    end else begin
                        st_nxt.chv[i][7:0] = pwdata[7:0];
                    end
                    st_nxt.pend[i/2] = (i % 2 == 1);
                end
            end
        end

        // overflow flag and buffered pair handover
        if (ovf) begin
            st_nxt.tof = 1'b1;
        end
        for (int q = 0; q < NP; q++) begin
            if (!st_r.mb[2*q]) begin
                st_nxt.act[q] = 1'b0;
            end else if (ovf) begin
                st_nxt.act[q] = st_nxt.pend[q];
            end
        end

        // channels
        for (int i = 0; i < NCH; i++) begin
            p    = i / 2;
            link = st_r.mb[2*p];
            odd  = (i % 2) == 1;
            oc   = !(link && odd) && (link || st_r.ma[i]);
            ic   = !(link && odd) && !oc && (st_r.els[i] != ELS_NONE);
            rise = st_nxt.pin_f[i] && !st_r.pin_f[i];
            fall = !st_nxt.pin_f[i] && st_r.pin_f[i];
            cmpv = (link && st_r.act[p]) ? st_r.chv[2*p+1] : st_r.chv[i];
            // edge is seen three clocks late, so the count has moved on by up to three
            cap  = ic && (((st_r.els[i] == ELS_RISE) && rise)
                       || ((st_r.els[i] == ELS_FALL) && fall)
                       || ((st_r.els[i] == ELS_BOTH) && (rise || fall)));
            // a value already passed is not matched until the next lap
            hit  = oc && step && (cnt_n == cmpv);
            if (cap) begin
                st_nxt.chv[i] = st_r.cnt;
            end
            if (cap || hit) begin
                st_nxt.cf[i] = 1'b1;
            end
            if (hit) begin
                case (st_r.els[i])
                    OC_TOGGLE: st_nxt.pin_o[i] = !st_r.pin_o[i];
                    OC_CLEAR:  st_nxt.pin_o[i] = 1'b0;
                    OC_SET:    st_nxt.pin_o[i] = 1'b1;
                    default: ;
                endcase
            end
            if (oc && ovf && st_r.tov[i]) begin
                st_nxt.pin_o[i] = !st_nxt.pin_o[i];
            end
        end

        // read data, taken in the setup cycle
        if (setup && !pwrite && mapped) begin
            rb = 8'h00;
            case (idx)
                MAIN_CTRL_IDX: rb = {st_r.tof, st_r.toie, st_r.halt, 2'h0, st_r.ps};
                CNT_HI_IDX:    rb = st_r.cnt[15:8];
                CNT_LO_IDX:    rb = st_r.cnt[7:0];
                MOD_HI_IDX:    rb = st_r.modv[15:8];
                MOD_LO_IDX:    rb = st_r.modv[7:0];
                default: ;
            endcase
            for (int i = 0; i < NCH; i++) begin
                cidx = CH0_CTRL_IDX + 6'(3 * i);
                if (idx == cidx) begin
                    rb = {st_r.cf[i], st_r.cie[i], st_r.mb[i], st_r.ma[i],
                          st_r.els[i], st_r.tov[i], st_r.cmax[i]};
                end
                if (idx == cidx + CH_HI_OFS) begin
                    rb = st_r.chv[i][15:8];
                end
                if (idx == cidx + CH_LO_OFS) begin
                    rb = st_r.chv[i][7:0];
                end
            end
            st_nxt.rdata = {24'h000000, rb};
        end

        // synchronous reset; channel values keep their contents
        if (sys_rst) begin
            st_nxt        = '0;
            st_nxt.modv   = MOD_RESET;
            st_nxt.halt   = HALT_RESET;
            st_nxt.chv    = st_r.chv;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // ********************************
    // pins and interrupt request
    // ********************************
    always_comb begin
        logic any;
        any = st_r.tof && st_r.toie;
        for (int i = 0; i < NCH; i++) begin
            channel_pin_oe[i] = !(st_r.mb[i - i % 2] && (i % 2 == 1))
                && (st_r.mb[i - i % 2] || st_r.ma[i])
                && (st_r.els[i] != ELS_NONE);
            if (!(st_r.mb[i - i % 2] && (i % 2 == 1)) && st_r.cf[i] && st_r.cie[i]) begin
                any = 1'b1;
            end
        end
        cpu_irq_req = any;
    end
    assign channel_pin_o = st_r.pin_o;

endmodule : sccc_unit

`default_nettype wire
